// ===== core/dlp_builder.sv
/*
 * Drive log page builder: directory, circular error log and statistics
 * page selection, read one byte per APB word through a sector window.
 * Assumes taskfile, command and error events come from logic on mclk.
 */
// Local design decisions: the APB interface to the registers and the register offsets.
// Behaviour
// RULE1: Directory starts with version word 0001h, or 0000h when absent.
// RULE2: Directory holds a 16-bit sector count per log address at 2N, 2N+1.
// RULE3: Host vendor logs 80h to 9Fh report sixteen sectors each.
// RULE4: Rejected faulty commands never create an error log entry.
// RULE5: Error sector holds version, index, four entries, count, checksum.
// RULE6: Error log version byte reads 01h.
// RULE7: Index names the newest entry, zero when empty, within zero to four.
// RULE8: Four entries form a circular buffer, fifth error overwrites first.
// RULE9: Unused entries read as zero bytes.
// RULE10: Entry: five 18-byte command records, then a 34-byte error record.
// RULE11: Command record keeps taskfile bytes, command code and ms timestamp.
// RULE12: Paired bytes keep newest write low, previous write high.
// RULE13: Error record keeps error, paired readbacks, status, state, hours.
// RULE14: Error readback low byte with control bit 7 clear, high when set.
// RULE15: State low nibble: unknown, sleep, standby, active, self-test.
// RULE16: Lifetime error count excludes rejects and saturates at maximum.
// RULE17: Unsupported statistics pages read as 512 zero bytes.
// RULE18: Revision 0000h means unsupported; trailing bytes are reserved.
// RULE19: Pages 00h, 01h, 03h to 06h are served; others are unsupported.
// RULE20: Host picks log and start sector; sectors start there regardless.
// RULE21: Checksum makes the error sector sum to zero; reserved bytes zero.
// RULE22: New error advances index cyclically and bumps count together.
`timescale 1ns/1ps
`default_nettype none
`include "dlp_defines.svh"
module dlp_builder #(
	parameter int MS_CYCLES = `DLP_MS_NS / `DLP_CLK_NS,
	parameter int HOUR_MS = `DLP_HOUR_MS,
	parameter logic [3:0] STATE_HI = 4'h0
) (
	input wire logic mclk, // Device clock.
	input wire logic nrst, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB write.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic tf_wr, // Taskfile register write pulse.
	input wire logic [2:0] tf_sel, // Taskfile register select.
	input wire logic [7:0] tf_data, // Taskfile write data.
	input wire logic cmd_issue, // Command issued pulse.
	input wire logic [7:0] cmd_code, // Command code with cmd_issue.
	input wire logic err_report, // Error reported pulse.
	input wire logic err_faulty, // Error was a rejected command.
	input wire logic [7:0] err_reg, // Error register.
	input wire logic [7:0] err_status, // Status register.
	input wire logic [7:0] err_devhead, // Device/head register.
	input wire logic [31:0] err_lo, // Readback with control bit 7 clear.
	input wire logic [31:0] err_hi, // Same four bytes with bit 7 set.
	input wire logic [3:0] dev_state // Power state at error report.
);
	generate
		if (MS_CYCLES < 2 || HOUR_MS < 2 || HOUR_MS > 4194303) begin : g_chk
			$error("dlp_builder: timing parameters out of range");
		end
	endgenerate

	localparam int MSW = $clog2(MS_CYCLES);
	localparam int EB = `DLP_ENTRY_BYTES;

	logic [MSW-1:0] ms_div_q;
	logic [31:0] ms_q;
	logic [21:0] hr_div_q;
	logic [15:0] hours_q;
	logic [7:0] cur_q [0:6];
	logic [7:0] prev_q [0:4];
	logic [719:0] hist_q;
	logic [EB*8-1:0] entry_q [0:3];
	logic [2:0] idx_q;
	logic [15:0] cnt_q;
	logic [23:0] sel_q;
	logic dir_en_q;
	logic [31:0] prdata_q;
	logic [7:0] chk;
	logic [7:0] win_byte;
	logic record;

	// Millisecond timestamp and lifetime hours.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ms_div_q <= '0;
			ms_q <= 32'h00000000;
			hr_div_q <= 22'h000000;
			hours_q <= 16'h0000;
		end else if (ms_div_q == MSW'(MS_CYCLES - 1)) begin
			ms_div_q <= '0;
			ms_q <= ms_q + 32'h00000001;
			if (hr_div_q == 22'(HOUR_MS - 1)) begin
				hr_div_q <= 22'h000000;
				hours_q <= hours_q + 16'h0001;
			end else begin
				hr_div_q <= hr_div_q + 22'h000001;
			end
		end else begin
			ms_div_q <= ms_div_q + MSW'(1);
		end
	end

	// RULE12: shadow previous value
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 7; i++) begin
				cur_q[i] <= 8'h00;
			end
			for (int i = 0; i < 5; i++) begin
				prev_q[i] <= 8'h00;
			end
		end else if (tf_wr && tf_sel <= 3'd6) begin
			cur_q[tf_sel] <= tf_data;
			if (tf_sel <= 3'd4) begin
				prev_q[tf_sel] <= cur_q[tf_sel];
			end
		end
	end

	// RULE11: command record capture
	// RULE10: newest record lands in the fifth slot
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hist_q <= '0;
		end else if (cmd_issue) begin
			hist_q <= {ms_q, 8'h00, cmd_code,
				cur_q[dlp_pkg::DLP_TF_DEVHEAD],
				prev_q[4], cur_q[4], prev_q[3], cur_q[3],
				prev_q[2], cur_q[2], prev_q[1], cur_q[1],
				prev_q[0], cur_q[0], cur_q[dlp_pkg::DLP_TF_DEVCTL],
				hist_q[719:144]};
		end
	end

	// RULE15: state byte encoding
	function automatic logic [7:0] state_byte(input logic [3:0] s);
		logic [3:0] lo;
		lo = (s <= 4'h4) ? s : 4'(dlp_pkg::DLP_ST_UNKNOWN);
		return {STATE_HI, lo};
	endfunction : state_byte

	// RULE4: faulty commands are not logged
	assign record = err_report && !err_faulty;

	// RULE22: index, entry and count update together
	// RULE8: circular entry replacement
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			idx_q <= 3'd0;
			for (int i = 0; i < 4; i++) begin
				entry_q[i] <= '0;
			end
		end else if (record) begin
			idx_q <= (idx_q == `DLP_IDX_MAX) ? 3'd1 : idx_q + 3'd1;
			// RULE13: error record layout
			// RULE14: bit 7 clear low, set high
			entry_q[(idx_q == `DLP_IDX_MAX) ? 2'd0 : idx_q[1:0]] <= {
				hours_q, state_byte(dev_state), 152'h0,
				err_status, err_devhead,
				err_hi[31:24], err_lo[31:24], err_hi[23:16], err_lo[23:16],
				err_hi[15:8], err_lo[15:8], err_hi[7:0], err_lo[7:0],
				err_reg, 8'h00, hist_q};
		end
	end

	// RULE16: saturating lifetime count
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 16'h0000;
		end else if (record && cnt_q != 16'hffff) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// RULE21: checksum over the error sector
	always_comb begin
		chk = `DLP_ERR_VERSION + {5'h00, idx_q} + cnt_q[7:0] + cnt_q[15:8];
		for (int e = 0; e < 4; e++) begin
			for (int b = 0; b < EB; b++) begin
				chk = chk + entry_q[e][b*8 +: 8];
			end
		end
		chk = 8'h00 - chk;
	end

	// RULE3: vendor logs sixteen sectors
	function automatic logic [15:0] dir_count(input logic [7:0] a);
		if (a >= `DLP_VND_LO && a <= `DLP_VND_HI) begin
			return `DLP_VND_SECTORS;
		end else if (a == `DLP_LOG_ERR) begin
			return `DLP_ERR_SECTORS;
		end else if (a == `DLP_LOG_STAT) begin
			return `DLP_STAT_SECTORS;
		end
		return 16'h0000;
	endfunction : dir_count

	// RULE1: version word then counts
	// RULE2: count low byte at 2N
	function automatic logic [7:0] dir_byte(input logic [8:0] n,
		input logic en);
		logic [15:0] w;
		w = (n[8:1] == 8'h00) ? `DLP_DIR_VERSION : dir_count(n[8:1]);
		if (!en) begin
			return 8'h00;
		end
		return n[0] ? w[15:8] : w[7:0];
	endfunction : dir_byte

	// RULE5: error sector layout
	// RULE9: entries reset to zero until used
	function automatic logic [7:0] err_byte(input logic [8:0] n);
		logic [8:0] off;
		off = n - `DLP_ENTRY0_OFF;
		if (n == 9'h000) begin
			return `DLP_ERR_VERSION;
		end else if (n == 9'h002) begin
			return {5'h00, idx_q};
		end else if (n == `DLP_CNT_OFF) begin
			return cnt_q[7:0];
		end else if (n == `DLP_CNT_OFF + 9'h001) begin
			return cnt_q[15:8];
		end else if (n == `DLP_CHK_OFF) begin
			return chk;
		end else if (n >= `DLP_ENTRY0_OFF && off < 9'(EB)) begin
			return entry_q[0][off*8 +: 8];
		end else if (n >= `DLP_ENTRY0_OFF && off < 9'(2*EB)) begin
			return entry_q[1][(off - 9'(EB))*8 +: 8];
		end else if (n >= `DLP_ENTRY0_OFF && off < 9'(3*EB)) begin
			return entry_q[2][(off - 9'(2*EB))*8 +: 8];
		end else if (n >= `DLP_ENTRY0_OFF && off < 9'(4*EB)) begin
			return entry_q[3][(off - 9'(3*EB))*8 +: 8];
		end
		return 8'h00;
	endfunction : err_byte

	// RULE19: supported page set
	function automatic logic page_ok(input logic [15:0] p);
		return p == 16'h0000 || p == 16'h0001 ||
			(p >= 16'h0003 && p <= 16'h0006);
	endfunction : page_ok

	// RULE17: unsupported pages all zero
	// RULE18: revision nonzero only on served pages
	function automatic logic [7:0] stat_byte(input logic [15:0] p,
		input logic [8:0] n);
		logic [15:0] rev;
		rev = (p == 16'h0001) ? `DLP_PAGE1_REV : `DLP_PAGE_REV;
		if (!page_ok(p)) begin
			return 8'h00;
		end else if (n == 9'h000) begin
			return rev[7:0];
		end else if (n == 9'h001) begin
			return rev[15:8];
		end else if (n == 9'h002) begin
			return p[7:0];
		end else if (p == 16'h0000 && n == 9'h008) begin
			return `DLP_PAGE_COUNT;
		end else if (p == 16'h0000 && n == 9'h009) begin
			return 8'h00;
		end else if (p == 16'h0000 && n == 9'h00a) begin
			return 8'h01;
		end else if (p == 16'h0000 && n >= 9'h00b && n <= 9'h00e) begin
			return 8'(n - 9'h008);
		end
		return 8'h00;
	endfunction : stat_byte

	// RULE20: selected log and start sector
	always_comb begin
		win_byte = 8'h00;
		if (sel_q[7:0] == `DLP_LOG_DIR && sel_q[23:8] == 16'h0000) begin
			win_byte = dir_byte(paddr[10:2], dir_en_q);
		end else if (sel_q[7:0] == `DLP_LOG_ERR &&
			sel_q[23:8] == 16'h0000) begin
			win_byte = err_byte(paddr[10:2]);
		end else if (sel_q[7:0] == `DLP_LOG_STAT) begin
			win_byte = stat_byte(sel_q[23:8], paddr[10:2]);
		end
	end

	function automatic logic mapped(input logic [11:0] a);
		return a[`DLP_WIN_BIT] || a == `DLP_A_LOG_SEL ||
			a == `DLP_A_ERR_STAT || a == `DLP_A_TIME_MS ||
			a == `DLP_A_HOURS || a == `DLP_A_DIR_CTRL;
	endfunction : mapped

	// Read data is sampled in the setup cycle so it leaves a flip-flop.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prdata_q <= 32'h00000000;
		end else if (psel && !penable) begin
			if (pwrite || paddr[1:0] != 2'b00) begin
				prdata_q <= 32'h00000000;
			end else if (paddr[`DLP_WIN_BIT]) begin
				prdata_q <= {24'h000000, win_byte};
			end else if (paddr == `DLP_A_LOG_SEL) begin
				prdata_q <= {8'h00, sel_q};
			end else if (paddr == `DLP_A_ERR_STAT) begin
				prdata_q <= {cnt_q, 13'h0000, idx_q};
			end else if (paddr == `DLP_A_TIME_MS) begin
				prdata_q <= ms_q;
			end else if (paddr == `DLP_A_HOURS) begin
				prdata_q <= {16'h0000, hours_q};
			end else if (paddr == `DLP_A_DIR_CTRL) begin
				prdata_q <= {31'h00000000, dir_en_q};
			end else begin
				prdata_q <= 32'h00000000;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sel_q <= `DLP_RST_SEL;
			dir_en_q <= `DLP_RST_DIR_EN;
		end else if (psel && penable && pwrite) begin
			if (paddr == `DLP_A_LOG_SEL) begin
				sel_q <= pwdata[23:0];
			end else if (paddr == `DLP_A_DIR_CTRL) begin
				dir_en_q <= pwdata[0];
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = psel && penable;
	assign pslverr = psel && penable && !mapped(paddr);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	idx_range_a: assert property (idx_q <= 3'd4) // RULE7
		else $error("error log index out of range");
	idx_wrap_a: assert property (record && idx_q == 3'd4 |=> // RULE8
		idx_q == 3'd1 && entry_q[0][719:0] == $past(hist_q))
		else $error("fifth error did not replace first entry");
	reject_skip_a: assert property (err_report && err_faulty // RULE4
		|=> $stable(idx_q) && $stable(cnt_q))
		else $error("rejected command was logged");
	count_sat_a: assert property (cnt_q == 16'hffff |=> // RULE16
		cnt_q == 16'hffff)
		else $error("error count wrapped");
	count_step_a: assert property (record && cnt_q != 16'hffff // RULE22
		|=> cnt_q == $past(cnt_q) + 16'h0001 && idx_q != 3'd0)
		else $error("count and index not updated together");
	vendor_dir_a: assert property (dir_en_q |-> // RULE3
		dir_byte(9'h100, 1'b1) == 8'h10 && dir_byte(9'h13f, 1'b1) == 8'h00)
		else $error("vendor log size wrong");
	dir_ver_a: assert property (dir_byte(9'h000, dir_en_q) == // RULE1
		{7'h00, dir_en_q})
		else $error("directory version wrong");
	unsup_page_a: assert property (psel && !penable && // RULE17
		paddr[`DLP_WIN_BIT] && sel_q[7:0] == 8'h04 &&
		!page_ok(sel_q[23:8]) |=> prdata == 32'h00000000)
		else $error("unsupported page not zero");
	err_ver_a: assert property (psel && !penable && !pwrite && // RULE6
		paddr == 12'h800 && sel_q == 24'h000003 |=> prdata == 32'h00000001)
		else $error("error log version not 01h");
	stamp_a: assert property (cmd_issue |=> // RULE11
		hist_q[719:688] == $past(ms_q) && hist_q[679:672] == $past(cmd_code))
		else $error("command record not captured");
	pair_a: assert property (tf_wr && tf_sel == 3'd1 |=> // RULE12
		cur_q[1] == $past(tf_data) && prev_q[1] == $past(cur_q[1]))
		else $error("paired register order wrong");

	wrap_c: cover property (record && idx_q == 3'd4);
	sat_c: cover property (record && cnt_q == 16'hffff);
	unsup_c: cover property (psel && penable && paddr[`DLP_WIN_BIT] &&
		sel_q == 24'h000204);
endmodule : dlp_builder
`default_nettype wire

// ===== include/dlp_defines.svh
/*
 * Offsets, field positions, reset values and timing figures for the drive
 * log page builder. Assumes the includer wants plain text macros only.
 */
`ifndef DLP_DEFINES_SVH
`define DLP_DEFINES_SVH
// APB register map, byte addresses.
`define DLP_A_LOG_SEL 12'h000
`define DLP_A_ERR_STAT 12'h004
`define DLP_A_TIME_MS 12'h008
`define DLP_A_HOURS 12'h00c
`define DLP_A_DIR_CTRL 12'h010
`define DLP_WIN_BIT 11
// Field positions.
`define DLP_SEL_LOG_LSB 0
`define DLP_SEL_SEC_LSB 8
`define DLP_STAT_CNT_LSB 16
// Reset values.
`define DLP_RST_DIR_EN 1'b1
`define DLP_RST_SEL 24'h000000
// Log addresses and contents.
`define DLP_LOG_DIR 8'h00
`define DLP_LOG_ERR 8'h03
`define DLP_LOG_STAT 8'h04
`define DLP_VND_LO 8'h80
`define DLP_VND_HI 8'h9f
`define DLP_VND_SECTORS 16'h0010
`define DLP_ERR_SECTORS 16'h0001
`define DLP_STAT_SECTORS 16'h0008
`define DLP_DIR_VERSION 16'h0001
`define DLP_ERR_VERSION 8'h01
`define DLP_ENTRY_BYTES 124
`define DLP_ENTRY0_OFF 9'h004
`define DLP_CNT_OFF 9'h1f4
`define DLP_CHK_OFF 9'h1ff
`define DLP_IDX_MAX 3'd4
`define DLP_PAGE_COUNT 8'h06
`define DLP_PAGE1_REV 16'h0002
`define DLP_PAGE_REV 16'h0001
// Timing.
`define DLP_CLK_NS 100
`define DLP_MS_NS 1000000
`define DLP_HOUR_MS 3600000
`endif

// ===== include/dlp_pkg.sv
/*
 * Types shared by the drive log page builder.
 * Assumes dlp_defines.svh provides the numeric constants.
 */
`default_nettype none
package dlp_pkg;
	// Power state reported with an error, low nibble of the state byte.
	typedef enum logic [3:0] {
		DLP_ST_UNKNOWN = 4'h0,
		DLP_ST_SLEEP = 4'h1,
		DLP_ST_STANDBY = 4'h2,
		DLP_ST_ACTIVE = 4'h3,
		DLP_ST_OFFLINE = 4'h4
	} dlp_state_t;
	// Paired taskfile register selects; devctl and devhead are unpaired.
	typedef enum logic [2:0] {
		DLP_TF_FEAT = 3'd0,
		DLP_TF_COUNT = 3'd1,
		DLP_TF_SECTOR = 3'd2,
		DLP_TF_CYL_LO = 3'd3,
		DLP_TF_CYL_HI = 3'd4,
		DLP_TF_DEVCTL = 3'd5,
		DLP_TF_DEVHEAD = 3'd6
	} dlp_tf_t;
endpackage : dlp_pkg
`default_nettype wire

// ===== bench/dlp_host_model.sv
/*
 * Host side model: taskfile writes, command issue and error reports.
 * Assumes it shares mclk with the builder and is steered by tasks.
 */
`timescale 1ns/1ps
`default_nettype none
module dlp_host_model (
	input wire logic mclk, // Device clock.
	output logic tf_wr, // Taskfile write pulse.
	output logic [2:0] tf_sel, // Register select.
	output logic [7:0] tf_data, // Write data.
	output logic cmd_issue, // Command pulse.
	output logic [7:0] cmd_code, // Command code.
	output logic err_report, // Error pulse.
	output logic err_faulty, // Rejected command flag.
	output logic [7:0] err_reg, // Error register.
	output logic [7:0] err_status, // Status register.
	output logic [7:0] err_devhead, // Device/head register.
	output logic [31:0] err_lo, // Readback, control bit 7 clear.
	output logic [31:0] err_hi, // Readback, control bit 7 set.
	output logic [3:0] dev_state // Power state.
);
	initial begin
		{tf_wr, cmd_issue, err_report, err_faulty} = 4'h0;
		tf_sel = 3'h7;
		{tf_data, cmd_code, err_reg, err_status, err_devhead} = 40'h0;
		{err_lo, err_hi} = 64'h0;
		dev_state = 4'h0;
	end
	// Data lines other than register select, status, device/head and state are inverted after each pulse so stale values never match.
	task automatic tf_write(input logic [2:0] s, input logic [7:0] d);
		@(posedge mclk);
		tf_wr <= 1'b1;
		tf_sel <= s;
		tf_data <= d;
		@(posedge mclk);
		tf_wr <= 1'b0;
		tf_data <= ~d;
	endtask : tf_write
	task automatic cmd(input logic [7:0] c);
		@(posedge mclk);
		cmd_issue <= 1'b1;
		cmd_code <= c;
		@(posedge mclk);
		cmd_issue <= 1'b0;
		cmd_code <= ~c;
	endtask : cmd
	task automatic report(input logic f, input logic [7:0] er,
		input logic [31:0] lo, input logic [31:0] hi, input logic [3:0] st);
		@(posedge mclk);
		err_report <= 1'b1;
		err_faulty <= f;
		err_reg <= er;
		err_status <= 8'h51;
		err_devhead <= 8'he0;
		err_lo <= lo;
		err_hi <= hi;
		dev_state <= st;
		@(posedge mclk);
		err_report <= 1'b0;
		err_faulty <= ~f;
		err_reg <= ~er;
		err_lo <= ~lo;
		err_hi <= ~hi;
	endtask : report
endmodule : dlp_host_model
`default_nettype wire

// ===== bench/drive_log_page_builder_tb.sv
/*
 * Self-checking bench for the log page builder over APB.
 * Assumes the host model drives all event inputs on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module drive_log_page_builder_tb;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, tf_wr, cmd_issue, err_report, err_faulty;
	logic [2:0] tf_sel;
	logic [7:0] tf_data, cmd_code, err_reg, err_status, err_devhead;
	logic [31:0] err_lo, err_hi;
	logic [3:0] dev_state;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	always #50 mclk = ~mclk;
	dlp_builder #(.MS_CYCLES(4), .HOUR_MS(3)) dut (.mclk(mclk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tf_wr(tf_wr), .tf_sel(tf_sel), .tf_data(tf_data),
		.cmd_issue(cmd_issue), .cmd_code(cmd_code), .err_report(err_report),
		.err_faulty(err_faulty), .err_reg(err_reg), .err_status(err_status),
		.err_devhead(err_devhead), .err_lo(err_lo), .err_hi(err_hi),
		.dev_state(dev_state));
	dlp_host_model host (.mclk(mclk), .tf_wr(tf_wr), .tf_sel(tf_sel),
		.tf_data(tf_data), .cmd_issue(cmd_issue), .cmd_code(cmd_code),
		.err_report(err_report), .err_faulty(err_faulty), .err_reg(err_reg),
		.err_status(err_status), .err_devhead(err_devhead), .err_lo(err_lo),
		.err_hi(err_hi), .dev_state(dev_state));
	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Waits for pready with no assumed latency; the cycle ceiling ends a hang.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic sel(input logic [7:0] lg, input logic [15:0] sec);
		logic [31:0] r;
		logic e;
		apb(1'b1, 12'h000, {8'h00, sec, lg}, r, e);
	endtask : sel
	task automatic cb(input string what, input logic [8:0] n,
		input logic [7:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, {1'b1, n, 2'b00}, 32'h0, r, e);
		chk(what, {24'h0, exp}, {24'h0, r[7:0]});
	endtask : cb
	task automatic t_dir();
		logic [31:0] r;
		logic e;
		sel(8'h00, 16'h0000);
		cb("dir ver lo", 9'h000, 8'h01);
		cb("dir ver hi", 9'h001, 8'h00);
		cb("dir err log", 9'h006, 8'h01);
		cb("dir stat log", 9'h008, 8'h08);
		cb("dir vnd 80 lo", 9'h100, 8'h10);
		cb("dir vnd 80 hi", 9'h101, 8'h00);
		cb("dir vnd 9f", 9'h13e, 8'h10);
		cb("dir a0", 9'h140, 8'h00);
		apb(1'b1, 12'h010, 32'h0, r, e);
		cb("dir absent", 9'h000, 8'h00);
		apb(1'b1, 12'h010, 32'h1, r, e);
		apb(1'b0, 12'h020, 32'h0, r, e);
		chk("unmapped", 32'h1, {31'h0, e});
	endtask : t_dir
	task automatic t_err();
		logic [31:0] r;
		logic e;
		logic [7:0] s;
		logic [8:0] b;
		int k;
		sel(8'h03, 16'h0000);
		cb("err ver", 9'h000, 8'h01);
		cb("err idx empty", 9'h002, 8'h00);
		host.report(1'b1, 8'h04, 32'h0, 32'h0, 4'h3);
		apb(1'b0, 12'h004, 32'h0, r, e);
		chk("faulty stat", 32'h0, r);
		host.tf_write(3'd0, 8'h11);
		host.tf_write(3'd0, 8'h22);
		host.tf_write(3'd6, 8'he0);
		host.tf_write(3'd1, 8'h33);
		host.tf_write(3'd5, 8'h08);
		host.cmd(8'h2f);
		// The sixth error carries a reserved state code, kept as unknown.
		for (int i = 1; i <= 6; i++) begin
			k = (i - 1) % 4;
			b = 9'(4 + k * 124);
			host.report(1'b0, 8'h40, 32'h44332211, 32'h88776655, 4'(i - 1));
			apb(1'b0, 12'h004, 32'h0, r, e);
			chk("err stat", {16'(i), 13'h0, 3'(k + 1)}, r);
			cb("state", b + 9'h079, i == 6 ? 8'h00 : 8'(i - 1));
			if (i == 1) begin
				cb("feat new", b + 9'h049, 8'h22);
				cb("feat old", b + 9'h04a, 8'h11);
				cb("count new", b + 9'h04b, 8'h33);
				cb("count old", b + 9'h04c, 8'h00);
				cb("cmd devctl", b + 9'h048, 8'h08);
				cb("cmd devhead", b + 9'h053, 8'he0);
				cb("cmd code", b + 9'h054, 8'h2f);
				cb("err reg", b + 9'h05b, 8'h40);
				cb("count clr", b + 9'h05c, 8'h11);
				cb("count set", b + 9'h05d, 8'h55);
				cb("cyl hi clr", b + 9'h062, 8'h44);
				cb("status", b + 9'h065, 8'h51);
				cb("unused", 9'h0db, 8'h00);
			end
		end
		cb("entry2 replaced", 9'h0f9, 8'h00);
		cb("entry3 kept", 9'h175, 8'h02);
		cb("idx byte", 9'h002, 8'h02);
		cb("count byte", 9'h1f4, 8'h06);
		cb("reserved", 9'h1f6, 8'h00);
		s = 8'h00;
		for (int i = 0; i < 512; i++) begin
			apb(1'b0, {1'b1, 9'(i), 2'b00}, 32'h0, r, e);
			s = s + r[7:0];
		end
		chk("checksum", 32'h0, {24'h0, s});
	endtask : t_err
	task automatic t_stat();
		logic [7:0] lst [6] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06};
		logic sup;
		for (int p = 0; p < 9; p++) begin
			sel(8'h04, 16'(p));
			sup = (p != 2 && p != 7 && p < 8);
			cb("rev lo", 9'h000, !sup ? 8'h00 : p == 1 ? 8'h02 : 8'h01);
			cb("rev hi", 9'h001, 8'h00);
			cb("page num", 9'h002, sup ? 8'(p) : 8'h00);
			cb("page tail", 9'h1ff, 8'h00);
		end
		sel(8'h04, 16'h0000);
		cb("page count", 9'h008, 8'h06);
		for (int i = 0; i < 6; i++) begin
			cb("page list", 9'(9 + i), lst[i]);
		end
		sel(8'h03, 16'h0001);
		cb("err sector 1", 9'h000, 8'h00);
	endtask : t_stat
	// Samples lie 120 cycles apart: 30 ticks of 4 cycles, 10 hours of 12.
	task automatic t_time();
		logic [31:0] ms0, ms1, hr0, hr1;
		logic e;
		apb(1'b0, 12'h008, 32'h0, ms0, e);
		apb(1'b0, 12'h00c, 32'h0, hr0, e);
		repeat (114) @(posedge mclk);
		apb(1'b0, 12'h008, 32'h0, ms1, e);
		apb(1'b0, 12'h00c, 32'h0, hr1, e);
		chk("ms step", 32'h0000001e, ms1 - ms0);
		chk("hours step", 32'h0000000a, hr1 - hr0);
	endtask : t_time
	initial begin
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		t_dir();
		t_err();
		t_stat();
		t_time();
		end_of_test();
	end
endmodule : drive_log_page_builder_tb
`default_nettype wire
